// ---- src/std_event_pkg.sv ----
package std_event_pkg;

  // ****************************************
  // event register layout
  // ****************************************
  localparam int EVT_WIDTH      = 16;
  localparam int EVT_USED       = 8;
  localparam int BIT_OP_DONE    = 0;
  localparam int BIT_REQ_CTRL   = 1;
  localparam int BIT_QUERY_ERR  = 2;
  localparam int BIT_DEV_ERR    = 3;
  localparam int BIT_EXEC_ERR   = 4;
  localparam int BIT_CMD_ERR    = 5;
  localparam int BIT_USER_REQ   = 6;
  localparam int BIT_POWER_ON   = 7;
  localparam int STB_SUMMARY    = 5;

  localparam logic [EVT_WIDTH-1:0] EVT_RESET   = 16'h0080;
  localparam logic [7:0]           ENA_RESET   = 8'h00;
  localparam logic [7:0]           UNUSED_MASK = 8'hBF;

  // ****************************************
  // enable write range and error code
  // ****************************************
  localparam int                  ENA_MAX      = 255;
  localparam logic signed [15:0]  ERR_OUT_OF_RANGE = -16'sd222;

  // ****************************************
  // common commands
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ_EVENTS,
    CMD_CLEAR_STATUS,
    CMD_READ_ENABLE,
    CMD_WRITE_ENABLE,
    CMD_OP_COMPLETE
  } cmd_t;

endpackage : std_event_pkg

// ---- src/event_latch.sv ----
`timescale 1ns/1ps
module event_latch
  import std_event_pkg::*;
#(
  parameter int WIDTH = EVT_USED
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // events and clear
  input  wire logic [WIDTH-1:0] setIn,
  input  wire logic             clearAll,
  // state
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // set wins over clear so an event in the read cycle survives
      always_ff @(posedge clk) begin
        if (rst) begin
          flags_r[i] <= EVT_RESET[i]; // [RL2]
        end else if (setIn[i]) begin
          flags_r[i] <= 1'b1; // [RL15]
        end else if (clearAll) begin
          flags_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flags_r;

endmodule : event_latch

// ---- src/enable_check.sv ----
`timescale 1ns/1ps
module enable_check
  import std_event_pkg::*;
(
  // requested value, signed integer
  input  wire logic signed [31:0] value,
  // result
  output logic                    inRange,
  output logic             [7:0]  mask
);

  assign inRange = (value >= 0) && (value <= ENA_MAX); // [RL13]
  assign mask    = value[7:0];

endmodule : enable_check

// ---- src/standard_event_status_group.sv ----
`timescale 1ns/1ps
// Behaviour
// [RL1] event bits 8 to 15 always read zero
// [RL2] bit 7 set after power cycle, until next read
// [RL3] user request bit 6 never set, reads zero
// [RL4] bit 5 set on syntax, semantic or trigger-in-message errors
// [RL5] bit 4 set on out-of-range data or hardware execution fault
// [RL6] bit 3 set on device dependent error such as overrange
// [RL7] bit 2 set on empty-queue read or lost output data
// [RL8] bit 1 set while requesting active controller role
// [RL9] bit 0 set only by operation-complete command when done
// [RL10] event query returns register value 0 to 255
// [RL11] event query clears all event bits
// [RL12] status byte bit 5 is OR of enabled event bits
// [RL13] enable writes outside 0 to 255 rejected with error -222
// [RL14] clear-status command clears event register
// [RL15] event bits stay set until read or cleared
module standard_event_status_group
  import std_event_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // command port
  input  wire cmd_t                   cmdCode,
  input  wire logic                   cmdValid,
  input  wire logic signed [31:0]     cmdValue,
  // fault conditions, one-cycle or level
  input  wire logic                   syntaxErr,
  input  wire logic                   semanticErr,
  input  wire logic                   triggerInMsg,
  input  wire logic                   dataRangeErr,
  input  wire logic                   hwExecErr,
  input  wire logic                   deviceErr,
  input  wire logic                   emptyQueueRead,
  input  wire logic                   outputLost,
  input  wire logic                   requestControl,
  input  wire logic                   opsPending,
  // response
  output logic                        respValid,
  output logic             [7:0]      respData,
  output logic                        errValid,
  output logic signed      [15:0]     errCode,
  // state
  output logic             [EVT_WIDTH-1:0] eventFlags,
  output logic             [7:0]      enableMask,
  output logic                        statusSummary
);

  // ****************************************
  // command decode
  // ****************************************
  wire logic readEvents  = cmdValid && (cmdCode == CMD_READ_EVENTS);
  wire logic clearStatus = cmdValid && (cmdCode == CMD_CLEAR_STATUS);
  wire logic readEnable  = cmdValid && (cmdCode == CMD_READ_ENABLE);
  wire logic writeEnable = cmdValid && (cmdCode == CMD_WRITE_ENABLE);
  wire logic opcCommand  = cmdValid && (cmdCode == CMD_OP_COMPLETE);

  // ****************************************
  // operation complete tracking
  // ****************************************
  // armed by the command, fires once nothing is pending any more
  logic opcArmed_r;
  logic opcArmed_nxt;
  wire  logic opcFire = (opcArmed_r || opcCommand) && !opsPending; // [RL9]

  assign opcArmed_nxt = opcFire ? 1'b0 : (opcArmed_r || opcCommand);

  always_ff @(posedge clk) begin
    if (rst) begin
      opcArmed_r <= 1'b0;
    end else begin
      opcArmed_r <= opcArmed_nxt;
    end
  end

  // ****************************************
  // event sources
  // ****************************************
  logic                enaInRange;
  logic [7:0]          enaMaskIn;
  logic [EVT_USED-1:0] setVec;

  assign setVec[BIT_OP_DONE]   = opcFire;                              // [RL9]
  assign setVec[BIT_REQ_CTRL]  = requestControl;                       // [RL8]
  assign setVec[BIT_QUERY_ERR] = emptyQueueRead || outputLost;         // [RL7]
  assign setVec[BIT_DEV_ERR]   = deviceErr;                            // [RL6]
  assign setVec[BIT_EXEC_ERR]  = dataRangeErr || hwExecErr ||
                                 (writeEnable && !enaInRange);         // [RL5]
  assign setVec[BIT_CMD_ERR]   = syntaxErr || semanticErr || triggerInMsg; // [RL4]
  assign setVec[BIT_USER_REQ]  = 1'b0;                                 // [RL3]
  assign setVec[BIT_POWER_ON]  = 1'b0;

  // power-on bit comes from the reset value of the latch

  // ****************************************
  // enable range check
  // ****************************************
  enable_check u_check (
    .value   (cmdValue),
    .inRange (enaInRange),
    .mask    (enaMaskIn)
  );

  // ****************************************
  // event latch
  // ****************************************
  logic [EVT_USED-1:0] flags;
  wire  logic          clearEvents = readEvents || clearStatus; // [RL11] [RL14]

  event_latch #(
    .WIDTH (EVT_USED)
  ) u_latch (
    .clk      (clk),
    .rst      (rst),
    .setIn    (setVec),
    .clearAll (clearEvents),
    .flags    (flags)
  );

  // reserved bits tied low, user request masked as well
  assign eventFlags = {{(EVT_WIDTH-EVT_USED){1'b0}}, flags & UNUSED_MASK}; // [RL1] [RL3]

  // ****************************************
  // enable register
  // ****************************************
  logic [7:0] enable_r;
  logic [7:0] enable_nxt;

  assign enable_nxt = (writeEnable && enaInRange) ? enaMaskIn : enable_r; // [RL13]

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r <= ENA_RESET;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  assign enableMask    = enable_r;
  // summary follows the flags, no extra latency
  assign statusSummary = |(eventFlags[EVT_USED-1:0] & enable_r); // [RL12]

  // ****************************************
  // responses
  // ****************************************
  logic               respValid_r;
  logic [7:0]         respData_r;
  logic               errValid_r;
  logic signed [15:0] errCode_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      respValid_r <= 1'b0;
      respData_r  <= 8'h00;
    end else begin
      respValid_r <= readEvents || readEnable;
      if (readEvents) begin
        respData_r <= eventFlags[EVT_USED-1:0]; // [RL10]
      end else if (readEnable) begin
        respData_r <= enable_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      errValid_r <= 1'b0;
      errCode_r  <= 16'sh0000;
    end else begin
      errValid_r <= writeEnable && !enaInRange; // [RL13]
      if (writeEnable && !enaInRange) begin
        errCode_r <= ERR_OUT_OF_RANGE;
      end
    end
  end

  assign respValid = respValid_r;
  assign respData  = respData_r;
  assign errValid  = errValid_r;
  assign errCode   = errCode_r;

endmodule : standard_event_status_group

// ---- sim/bus_ctrl_model.sv ----
`timescale 1ns/1ps
module bus_ctrl_model
  import std_event_pkg::*;
(
  // clock and bench request
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               go,
  input  wire cmd_t               op,
  input  wire logic signed [31:0] val,
  // device command port
  output cmd_t                    cmdCode,
  output logic                    cmdValid,
  output logic signed [31:0]      cmdValue
);
  // idle operand toggles so a stale value never passes for a live one
  always_ff @(posedge clk) begin
    cmdValid <= go && !rst;
    cmdCode  <= go ? op : CMD_NONE;
    cmdValue <= go ? val : (rst ? '0 : ~cmdValue);
  end
endmodule : bus_ctrl_model

// ---- sim/event_group_properties.sv ----
`timescale 1ns/1ps
module event_group_checker
  import std_event_pkg::*;
(
  // ****************************************
  // watched ports
  // ****************************************
  input wire logic                  clk,
  input wire logic                  rst,
  input wire cmd_t                  cmdCode,
  input wire logic                  cmdValid,
  input wire logic signed [31:0]    cmdValue,
  input wire logic                  syntaxErr,
  input wire logic                  respValid,
  input wire logic [7:0]            respData,
  input wire logic                  errValid,
  input wire logic signed [15:0]    errCode,
  input wire logic [EVT_WIDTH-1:0]  eventFlags,
  input wire logic [7:0]            enableMask,
  input wire logic                  statusSummary
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       rdEv   = cmdValid && cmdCode == CMD_READ_EVENTS;
  wire       clsCmd = cmdValid && cmdCode == CMD_CLEAR_STATUS;
  wire       wrEn   = cmdValid && cmdCode == CMD_WRITE_ENABLE;
  wire       bad    = cmdValue < 0 || cmdValue > ENA_MAX;
  wire [7:0] valLow = cmdValue[7:0];
  wire [7:0] evLow  = eventFlags[7:0];
  property p_resv; eventFlags[15:8] == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_user; !eventFlags[BIT_USER_REQ]; endproperty
  a_user: assert property (p_user) else $error("user bit set");
  property p_read; rdEv |=> respValid && respData == $past(evLow); endproperty
  a_read: assert property (p_read) else $error("bad read answer");
  property p_clear; rdEv |=> !eventFlags[BIT_POWER_ON]; endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");
  property p_cls; clsCmd |=> !eventFlags[BIT_POWER_ON]; endproperty
  a_cls: assert property (p_cls) else $error("clear did not clear");
  property p_sum; statusSummary == |(evLow & enableMask); endproperty
  a_sum: assert property (p_sum) else $error("bad summary");
  property p_refuse;
    wrEn && bad |=> errValid && errCode == ERR_OUT_OF_RANGE && $stable(enableMask);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad refusal");
  property p_accept; wrEn && !bad |=> enableMask == $past(valLow) && !errValid; endproperty
  a_accept: assert property (p_accept) else $error("bad enable write");
  property p_cmderr; syntaxErr |=> eventFlags[BIT_CMD_ERR]; endproperty
  a_cmderr: assert property (p_cmderr) else $error("command error lost");
  property p_hold; eventFlags[BIT_CMD_ERR] && !rdEv && !clsCmd |=> eventFlags[BIT_CMD_ERR];
  endproperty
  a_hold: assert property (p_hold) else $error("event bit dropped");
endmodule : event_group_checker
bind standard_event_status_group event_group_checker u_chk (.clk(clk), .rst(rst),
  .cmdCode(cmdCode), .cmdValid(cmdValid), .cmdValue(cmdValue), .syntaxErr(syntaxErr),
  .respValid(respValid), .respData(respData), .errValid(errValid), .errCode(errCode),
  .eventFlags(eventFlags), .enableMask(enableMask), .statusSummary(statusSummary));

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import std_event_pkg::*;
  logic clk = 0, rst = 1, go = 0, pend = 0, respValid, errValid, statusSummary, cmdValid;
  logic [8:0] flt = '0;
  cmd_t op = CMD_NONE, cmdCode;
  logic signed [31:0] val = 0, cmdValue;
  logic signed [15:0] errCode;
  logic [15:0] eventFlags;
  logic [7:0] respData, enableMask;
  int failCount = 0, nTests = 0;
  // ****************************************
  // expected byte per fault input, in port order
  // ****************************************
  logic [7:0] rowExp [9] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02};
  logic signed [31:0] badVal [2] = '{256, -1};
  always #12.5 clk = ~clk;
  bus_ctrl_model host (.clk(clk), .rst(rst), .go(go), .op(op), .val(val),
    .cmdCode(cmdCode), .cmdValid(cmdValid), .cmdValue(cmdValue));
  standard_event_status_group DUT (.clk(clk), .rst(rst), .cmdCode(cmdCode),
    .cmdValid(cmdValid), .cmdValue(cmdValue), .syntaxErr(flt[0]), .semanticErr(flt[1]),
    .triggerInMsg(flt[2]), .dataRangeErr(flt[3]), .hwExecErr(flt[4]), .deviceErr(flt[5]),
    .emptyQueueRead(flt[6]), .outputLost(flt[7]), .requestControl(flt[8]),
    .opsPending(pend), .respValid(respValid), .respData(respData), .errValid(errValid),
    .errCode(errCode), .eventFlags(eventFlags), .enableMask(enableMask),
    .statusSummary(statusSummary));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tallyAndFinish();
    if (failCount == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tallyAndFinish
  // ends just after the edge on which the device took the command, answer visible
  task automatic cmd(input cmd_t c, input logic signed [31:0] v);
    @(posedge clk); #1 go = 1; op = c; val = v;
    @(posedge clk); #1 go = 0;
    @(posedge clk); #1;
  endtask : cmd
  task automatic rd(input logic [7:0] exp);
    cmd(CMD_READ_EVENTS, 0);
    check(respValid, 1);
    check(respData, exp);
    check(eventFlags, 16'h0000);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk); #1 flt[i] = 1;
    @(posedge clk); #1 flt[i] = 0;
  endtask : pulse
  initial begin
    repeat (4000) @(posedge clk);
    failCount++;
    tallyAndFinish();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(8'h80);
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      repeat (3) @(posedge clk);
      rd(rowExp[i]);
    end
    pend = 1;
    cmd(CMD_OP_COMPLETE, 0);
    rd(8'h00);
    pend = 0;
    repeat (2) @(posedge clk);
    #1 rd(8'h01);
    cmd(CMD_WRITE_ENABLE, 36);
    check(statusSummary, 0);
    pulse(6);
    check(statusSummary, 1);
    cmd(CMD_CLEAR_STATUS, 0);
    check(eventFlags, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      cmd(CMD_WRITE_ENABLE, badVal[k]);
      check(errValid, 1);
      check(errCode, 16'hFF22);
      rd(8'h10);
    end
    cmd(CMD_READ_ENABLE, 0);
    check(respData, 8'h24);
    // reset in mid-run must bring back the power-on bit and clear the enable mask
    @(posedge clk); #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    check(eventFlags, 16'h0080);
    check(enableMask, 8'h00);
    rd(8'h80);
    tallyAndFinish();
  end
endmodule : testbench
